// file: hw/bpsc_pkg.sv
/*
  Constants, field layout and types of the bridge power state control block.
  Assumes nothing of its surroundings; included by every design file.
*/
`default_nettype none

package bpsc_pkg;

  // Configuration space
  localparam logic [7:0] PMCS_OFFSET = 8'h84;

  // Power state field codes
  localparam logic [1:0] PWR_D0 = 2'h0;
  localparam logic [1:0] PWR_D1 = 2'h1;
  localparam logic [1:0] PWR_D2 = 2'h2;
  localparam logic [1:0] PWR_D3 = 2'h3;

  // Field positions
  localparam int PWR_LSB           = 0;
  localparam int PWR_MSB           = 1;
  localparam int WAKE_EN_BIT       = 8;
  localparam int DATA_SEL_LSB      = 9;
  localparam int DATA_SEL_MSB      = 12;
  localparam int DATA_SCALE_LSB    = 13;
  localparam int DATA_SCALE_MSB    = 14;
  localparam int WAKE_STS_BIT      = 15;
  localparam int HB_STS_MABORT_BIT = 13;

  // Values after reset
  localparam logic [1:0]  PWR_RESET     = PWR_D0;
  localparam logic        WAKE_EN_RESET = 1'b0;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

  // Kinds of downstream cycle
  typedef enum logic [1:0] {
    DS_MEM,
    DS_IO,
    DS_CFG0,
    DS_CFG1
  } bpsc_ds_kind_t;

  // Only D0 and D3 may be stored
  function automatic logic bpsc_pwr_supported(input logic [1:0] code);
    return (code == PWR_D0) || (code == PWR_D3);
  endfunction

endpackage

`default_nettype wire

// file: hw/bpsc_state_reg.sv
/*
  Storage of the power state field and the wake enable bit.
  Assumes write strobes that are already decoded to this register and byte lane.
*/
`timescale 1ns/1ps
`default_nettype none

module bpsc_state_reg
  import bpsc_pkg::*;
(
  // Clock and resets
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       por_rst_b,
  // Write side
  input  wire logic       wr_lo,
  input  wire logic       wr_hi,
  input  wire logic [1:0] wr_state,
  input  wire logic       wr_wake_en,
  // Stored fields
  output logic      [1:0] power_state_ff,
  output logic            wake_enable_ff
);

  logic [1:0] nxt_power_state;
  logic       nxt_wake_enable;

  // Unsupported codes complete but leave the state alone
  assign nxt_power_state = (wr_lo && bpsc_pwr_supported(wr_state)) ? wr_state : power_state_ff;
  assign nxt_wake_enable = wr_hi ? wr_wake_en : wake_enable_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_state_ff <= PWR_RESET;
    end else begin
      power_state_ff <= nxt_power_state;
    end
  end

  // Sticky: only power-on reset clears it, platform reset does not
  always_ff @(posedge clk or negedge por_rst_b) begin
    if (!por_rst_b) begin
      wake_enable_ff <= WAKE_EN_RESET;
    end else begin
      wake_enable_ff <= nxt_wake_enable;
    end
  end

endmodule

`default_nettype wire

// file: hw/bpsc_ds_gate.sv
/*
  Claim or master-abort decision for downstream cycles.
  Assumes one-cycle request pulses from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module bpsc_ds_gate
  import bpsc_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // State
  input  wire logic          in_d0,
  // Downstream request
  input  wire logic          ds_req,
  input  wire bpsc_ds_kind_t ds_kind,
  // Answer
  output logic               ds_ack_ff,
  output logic               ds_claim_ff,
  output logic               ds_mabort_ff
);

  logic pass;

  // Type 0 config still passes outside D0
  assign pass = in_d0 || (ds_kind == DS_CFG0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ds_ack_ff    <= 1'b0;
      ds_claim_ff  <= 1'b0;
      ds_mabort_ff <= 1'b0;
    end else begin
      ds_ack_ff    <= ds_req;
      ds_claim_ff  <= ds_req && pass;
      ds_mabort_ff <= ds_req && !pass;
    end
  end

endmodule

`default_nettype wire

// file: hw/bpsc_top.sv
/*
  Power management control/status register of a bridge function, with the
  gating that the power state imposes on downstream, register and interrupt
  traffic. Assumes all requests come from logic on clk as one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none

module bpsc_top
  import bpsc_pkg::*;
(
  // Clock and resets
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          por_rst_b,
  // Configuration access
  input  wire logic          cfg_req,
  input  wire logic          cfg_wr,
  input  wire logic [7:0]    cfg_addr,
  input  wire logic [3:0]    cfg_be,
  input  wire logic [31:0]   cfg_wdata,
  output logic               cfg_ack_ff,
  output logic [31:0]        cfg_rdata_ff,
  // Downstream cycles
  input  wire logic          ds_req,
  input  wire bpsc_ds_kind_t ds_kind,
  output logic               ds_ack,
  output logic               ds_claim,
  output logic               ds_mabort,
  // Host bridge status logging
  output logic [15:0]        hb_status_set_ff,
  // Memory-mapped register cycles
  input  wire logic          regcyc_req,
  output logic               regcyc_ack_ff,
  // Interrupts
  input  wire logic          irq_in,
  output logic               irq_out_ff,
  // Status
  output logic               func_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Register access decode

  logic [1:0]  power_state;
  logic        wake_enable;
  logic        in_d0;
  logic        hit;
  logic        wr_lo;
  logic        wr_hi;
  logic [31:0] reg_view;
  logic [31:0] nxt_rdata;

  assign in_d0       = (power_state == PWR_D0);
  assign func_active = in_d0;

  // Config path is never gated by power state
  assign hit   = cfg_req && (cfg_addr[7:2] == PMCS_OFFSET[7:2]);
  assign wr_lo = hit && cfg_wr && cfg_be[0];
  assign wr_hi = hit && cfg_wr && cfg_be[1];

  // Read-only and reserved bits are tied, never stored
  always_comb begin
    reg_view                                = 32'h0000_0000;
    reg_view[PWR_MSB:PWR_LSB]               = power_state;
    reg_view[WAKE_EN_BIT]                   = wake_enable;
    reg_view[DATA_SEL_MSB:DATA_SEL_LSB]     = 4'h0;
    reg_view[DATA_SCALE_MSB:DATA_SCALE_LSB] = 2'h0;
    reg_view[WAKE_STS_BIT]                  = 1'b0;
  end

  // Other offsets read zero but still complete
  assign nxt_rdata = (hit && !cfg_wr) ? reg_view : RDATA_RESET;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ack_ff   <= 1'b0;
      cfg_rdata_ff <= RDATA_RESET;
    end else begin
      cfg_ack_ff   <= cfg_req;
      cfg_rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored fields

  bpsc_state_reg u_state (
    .clk            (clk),
    .rst_b          (rst_b),
    .por_rst_b      (por_rst_b),
    .wr_lo          (wr_lo),
    .wr_hi          (wr_hi),
    .wr_state       (cfg_wdata[PWR_MSB:PWR_LSB]),
    .wr_wake_en     (cfg_wdata[WAKE_EN_BIT]),
    .power_state_ff (power_state),
    .wake_enable_ff (wake_enable)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Downstream gating and abort logging

  logic ds_mabort_int;

  bpsc_ds_gate u_gate (
    .clk          (clk),
    .rst_b        (rst_b),
    .in_d0        (in_d0),
    .ds_req       (ds_req),
    .ds_kind      (ds_kind),
    .ds_ack_ff    (ds_ack),
    .ds_claim_ff  (ds_claim),
    .ds_mabort_ff (ds_mabort_int)
  );

  assign ds_mabort = ds_mabort_int;

  // One-cycle set pulse into the host bridge status, bit 13 only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hb_status_set_ff <= 16'h0000;
    end else begin
      hb_status_set_ff                    <= 16'h0000;
      hb_status_set_ff[HB_STS_MABORT_BIT] <= ds_mabort_int;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register cycles and interrupts, silenced outside D0

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regcyc_ack_ff <= 1'b0;
      irq_out_ff    <= 1'b0;
    end else begin
      regcyc_ack_ff <= regcyc_req && in_d0;
      irq_out_ff <= irq_in && in_d0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_state_reject_bad: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_lo && !bpsc_pwr_supported(cfg_wdata[1:0])) |=> $stable(power_state))
    else $error("unsupported power state was stored");

  a_state_take_good: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_lo && bpsc_pwr_supported(cfg_wdata[1:0])) |=> (power_state == $past(cfg_wdata[1:0])))
    else $error("supported power state not stored");

  a_cfg_always_ack: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_req |=> cfg_ack_ff)
    else $error("config access not answered");

  a_state_readback: assert property (@(posedge clk) disable iff (!rst_b)
    (hit && !cfg_wr) |=> (cfg_rdata_ff[1:0] == $past(power_state)))
    else $error("power state readback wrong");

  a_ro_bits_zero: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_ack_ff |-> (cfg_rdata_ff[WAKE_STS_BIT] == 1'b0))
    else $error("wake status read nonzero");

  a_data_fields_zero: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_ack_ff |-> (cfg_rdata_ff[14:9] == 6'h00))
    else $error("data scale or select nonzero");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_ack_ff |-> (cfg_rdata_ff[31:16] == 16'h0000 && cfg_rdata_ff[7:2] == 6'h00))
    else $error("reserved bits read nonzero");

  a_wake_en_store: assert property (@(posedge clk) disable iff (!por_rst_b)
    wr_hi |=> (wake_enable == $past(cfg_wdata[WAKE_EN_BIT])))
    else $error("wake enable not stored");

  a_ds_abort_d3: assert property (@(posedge clk) disable iff (!rst_b)
    (ds_req && !in_d0 && ds_kind != DS_CFG0) |=> (ds_mabort && !ds_claim))
    else $error("downstream cycle claimed outside D0");

  a_ds_cfg0_pass: assert property (@(posedge clk) disable iff (!rst_b)
    (ds_req && (in_d0 || ds_kind == DS_CFG0)) |=> (ds_claim && !ds_mabort))
    else $error("downstream cycle wrongly aborted");

  a_abort_logged: assert property (@(posedge clk) disable iff (!rst_b)
    ds_mabort |=> hb_status_set_ff[HB_STS_MABORT_BIT])
    else $error("master abort not logged");

  a_irq_silent_d3: assert property (@(posedge clk) disable iff (!rst_b)
    (!in_d0 && $past(!in_d0)) |-> !irq_out_ff)
    else $error("interrupt raised outside D0");

  a_regcyc_silent_d3: assert property (@(posedge clk) disable iff (!rst_b)
    (regcyc_req && !in_d0) |=> !regcyc_ack_ff)
    else $error("register cycle answered outside D0");

  a_active_rise_d0: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(func_active) |-> $past(wr_lo && (cfg_wdata[PWR_MSB:PWR_LSB] == PWR_D0)))
    else $error("function became active without a D0 write");

  a_reset_d0: assert property (@(posedge clk)
    $rose(rst_b) |-> (power_state == PWR_D0))
    else $error("power state not D0 after reset");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: configuration side
  // Config path must stay alive in every state, or D3 could never be left

  a_active_fall_d3: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(func_active) |-> $past(wr_lo && (cfg_wdata[PWR_MSB:PWR_LSB] == PWR_D3)))
    else $error("function left D0 without a D3 write");

  a_state_legal: assert property (@(posedge clk) disable iff (!rst_b)
    (power_state == PWR_D0) || (power_state == PWR_D3))
    else $error("unsupported power state held");

  a_state_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !wr_lo |=> $stable(power_state))
    else $error("power state changed without a write");

  a_wake_en_hold: assert property (@(posedge clk) disable iff (!por_rst_b)
    !wr_hi |=> $stable(wake_enable))
    else $error("wake enable changed without a write");

  a_rdata_wake: assert property (@(posedge clk) disable iff (!rst_b)
    (hit && !cfg_wr) |=> (cfg_rdata_ff[WAKE_EN_BIT] == $past(wake_enable)))
    else $error("wake enable readback wrong");

  a_rdata_miss_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_req && !hit) |=> (cfg_rdata_ff == 32'h0000_0000))
    else $error("other offset read nonzero");

  a_cfg_ack_only: assert property (@(posedge clk) disable iff (!rst_b)
    !cfg_req |=> !cfg_ack_ff)
    else $error("config answer without request");

  a_cfg_d3_served: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_req && !in_d0) |=> cfg_ack_ff)
    else $error("config access dropped outside D0");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: downstream and logging
  // Decisions use the state seen with the request, not the one after it

  a_ds_ack_follow: assert property (@(posedge clk) disable iff (!rst_b)
    ds_req |=> ds_ack)
    else $error("downstream cycle not answered");

  a_ds_idle_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    !ds_req |=> !(ds_ack || ds_claim || ds_mabort))
    else $error("downstream answer without request");

  a_ds_one_answer: assert property (@(posedge clk) disable iff (!rst_b)
    ds_ack |-> (ds_claim != ds_mabort))
    else $error("downstream answer not claim xor abort");

  a_abort_cause: assert property (@(posedge clk) disable iff (!rst_b)
    ds_mabort |-> ($past(!in_d0) && ($past(ds_kind) != DS_CFG0)))
    else $error("downstream cycle aborted without cause");

  a_claim_cause: assert property (@(posedge clk) disable iff (!rst_b)
    ds_claim |-> $past(in_d0 || (ds_kind == DS_CFG0)))
    else $error("downstream cycle claimed outside D0");

  a_log_cause: assert property (@(posedge clk) disable iff (!rst_b)
    hb_status_set_ff[HB_STS_MABORT_BIT] |-> $past(ds_mabort))
    else $error("master abort logged without abort");

  a_log_one_bit: assert property (@(posedge clk) disable iff (!rst_b)
    (hb_status_set_ff[15:14] == 2'h0) && (hb_status_set_ff[12:0] == 13'h0000))
    else $error("wrong host bridge status bit set");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: register cycles and interrupts
  // Only D0 lets these through

  a_regcyc_pass_d0: assert property (@(posedge clk) disable iff (!rst_b)
    (regcyc_req && in_d0) |=> regcyc_ack_ff)
    else $error("register cycle not answered in D0");

  a_regcyc_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    !regcyc_req |=> !regcyc_ack_ff)
    else $error("register cycle answer without request");

  a_irq_pass_d0: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_in && in_d0) |=> irq_out_ff)
    else $error("interrupt not passed in D0");

  a_irq_follow: assert property (@(posedge clk) disable iff (!rst_b)
    !irq_in |=> !irq_out_ff)
    else $error("interrupt raised without source");

endmodule

`default_nettype wire

// file: tb/bpsc_host.sv
/*
  Host partner model: issues configuration, downstream and register cycles.
  Assumes the bench calls its tasks; all requests change at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none

module bpsc_host
  import bpsc_pkg::*;
(
  // Clock
  input  wire logic          clk,
  // Requests
  output logic               cfg_req,
  output logic               cfg_wr,
  output logic [7:0]         cfg_addr,
  output logic [3:0]         cfg_be,
  output logic [31:0]        cfg_wdata,
  output logic               ds_req,
  output var bpsc_ds_kind_t  ds_kind,
  output logic               regcyc_req,
  // Answers
  input  wire logic          cfg_ack_ff,
  input  wire logic [31:0]   cfg_rdata_ff,
  input  wire logic          ds_ack,
  input  wire logic          ds_claim,
  input  wire logic          ds_mabort,
  input  wire logic [15:0]   hb_status_set_ff,
  input  wire logic          regcyc_ack_ff
);
  initial begin
    {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata, ds_req, regcyc_req} = '0;
    ds_kind = DS_MEM;
  end

  // Released lines show the inverse, so stale data is never mistaken for valid
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                     output logic ack, output logic [31:0] rd);
    @(negedge clk);
    {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, w, a, be, d};
    @(negedge clk);
    ack = cfg_ack_ff;
    rd = cfg_rdata_ff;
    {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b0, ~w, ~a, ~be, ~d};
  endtask

  task automatic ds(input bpsc_ds_kind_t k, output logic ack, output logic clm, output logic mab,
                    output logic [15:0] hb);
    @(negedge clk);
    ds_req = 1'b1;
    ds_kind = k;
    @(negedge clk);
    {ack, clm, mab} = {ds_ack, ds_claim, ds_mabort};
    ds_req = 1'b0;
    @(negedge clk);
    hb = hb_status_set_ff;
  endtask

  task automatic regcyc(output logic ack);
    @(negedge clk);
    regcyc_req = 1'b1;
    @(negedge clk);
    ack = regcyc_ack_ff;
    regcyc_req = 1'b0;
  endtask
endmodule

`default_nettype wire

// file: tb/tb_bridge_power_state_control.sv
/*
  Self-checking bench of the bridge power state control block.
  Assumes the host partner model in bpsc_host drives all request ports.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_bridge_power_state_control
  import bpsc_pkg::*;
;
  logic          clk = 1'b0;
  logic          rst_b, por_rst_b, irq_in;
  logic          cfg_req, cfg_wr, cfg_ack_ff, ds_req, ds_ack, ds_claim, ds_mabort;
  logic          regcyc_req, regcyc_ack_ff, irq_out_ff, func_active;
  logic [7:0]    cfg_addr;
  logic [3:0]    cfg_be;
  logic [31:0]   cfg_wdata, cfg_rdata_ff;
  logic [15:0]   hb_status_set_ff;
  bpsc_ds_kind_t ds_kind;
  int            n_errors = 0;
  int            check_count = 0;

  always #5 clk = ~clk;

  bpsc_top uut (.clk(clk), .rst_b(rst_b), .por_rst_b(por_rst_b), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack_ff(cfg_ack_ff),
    .cfg_rdata_ff(cfg_rdata_ff), .ds_req(ds_req), .ds_kind(ds_kind), .ds_ack(ds_ack),
    .ds_claim(ds_claim), .ds_mabort(ds_mabort), .hb_status_set_ff(hb_status_set_ff),
    .regcyc_req(regcyc_req), .regcyc_ack_ff(regcyc_ack_ff), .irq_in(irq_in), .irq_out_ff(irq_out_ff),
    .func_active(func_active));

  bpsc_host host (.clk(clk), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .ds_req(ds_req), .ds_kind(ds_kind), .regcyc_req(regcyc_req),
    .cfg_ack_ff(cfg_ack_ff), .cfg_rdata_ff(cfg_rdata_ff), .ds_ack(ds_ack), .ds_claim(ds_claim),
    .ds_mabort(ds_mabort), .hb_status_set_ff(hb_status_set_ff), .regcyc_ack_ff(regcyc_ack_ff));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic        ack;
    logic [31:0] r;
    host.cfg(1'b0, a, 4'hF, 32'h0, ack, r);
    chk({31'h0, ack}, 32'h1);
    chk(r, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic        ack;
    logic [31:0] r;
    host.cfg(1'b1, a, be, d, ack, r);
    chk({31'h0, ack}, 32'h1);
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    logic          a, c, m;
    logic [15:0]   hb;
    bpsc_ds_kind_t k;
    rst_b = 1'b0;
    por_rst_b = 1'b0;
    irq_in = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    por_rst_b = 1'b1;
    rd(PMCS_OFFSET, 32'h0);
    chk({31'h0, func_active}, 32'h1);
    $display("test reset done");
    wr(PMCS_OFFSET, 4'hF, 32'hFFFF_FFFF);
    rd(PMCS_OFFSET, 32'h103);
    chk({31'h0, func_active}, 32'h0);
    $display("test write d3 done");
    irq_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      k = bpsc_ds_kind_t'(i);
      host.ds(k, a, c, m, hb);
      chk({31'h0, a}, 32'h1);
      chk({31'h0, c}, {31'h0, k == DS_CFG0});
      chk({31'h0, m}, {31'h0, k != DS_CFG0});
      chk({16'h0, hb}, (k != DS_CFG0) ? 32'h2000 : 32'h0);
    end
    host.regcyc(a);
    chk({31'h0, a}, 32'h0);
    chk({31'h0, irq_out_ff}, 32'h0);
    rd(PMCS_OFFSET, 32'h103);
    $display("test d3 gating done");
    for (int i = 1; i < 3; i++) begin
      wr(PMCS_OFFSET, 4'h1, i);
      rd(PMCS_OFFSET, 32'h103);
    end
    $display("test unsupported states done");
    wr(PMCS_OFFSET, 4'h1, 32'h0);
    chk({31'h0, func_active}, 32'h1);
    rd(PMCS_OFFSET, 32'h100);
    chk({31'h0, irq_out_ff}, 32'h1);
    host.regcyc(a);
    chk({31'h0, a}, 32'h1);
    host.ds(DS_MEM, a, c, m, hb);
    chk({29'h0, a, c, m}, 32'h6);
    chk({16'h0, hb}, 32'h0);
    $display("test return d0 done");
    wr(PMCS_OFFSET, 4'h1, 32'h3);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rd(PMCS_OFFSET, 32'h100);
    chk({31'h0, func_active}, 32'h1);
    wr(8'h88, 4'hF, 32'hFFFF_FFFF);
    rd(8'h88, 32'h0);
    wr(PMCS_OFFSET, 4'h2, 32'h0);
    rd(PMCS_OFFSET, 32'h0);
    $display("test sticky and unmapped done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
